// >>> design/cpl_event_packer.sv
`timescale 1ns/1ps
module cpl_event_packer #(
  parameter int N_SRC = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [N_SRC-1:0] ev_in,
  input wire logic [N_SRC-1:0] ev_enable,
  input wire logic tx_ready,
  input wire logic reply_valid,
  input wire logic [15:0] reply_tag,
  output logic ev_send,
  output logic [N_SRC-1:0] ev_sent_mask,
  output logic [15:0] ev_tag,
  output logic in_flight
);
  logic [N_SRC-1:0] pend_q;
  logic done;
  logic start;

  assign done = in_flight && reply_valid && (reply_tag == ev_tag);
  assign start = !in_flight && tx_ready && (|pend_q);

  for (genvar i = 0; i < N_SRC; i++) begin : g_src
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pend_q[i] <= 1'b0;
      else if (ev_in[i] && ev_enable[i]) pend_q[i] <= 1'b1;
      else if (start) pend_q[i] <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ev_send <= 1'b0;
      ev_sent_mask <= '0;
      ev_tag <= cpl_pkg::TAG_RST;
      in_flight <= 1'b0;
    end else begin
      ev_send <= start;
      if (start) begin
        ev_sent_mask <= pend_q;
        in_flight <= 1'b1;
      end else if (done) begin
        in_flight <= 1'b0;
        ev_tag <= (ev_tag == 16'hffff) ? cpl_pkg::TAG_WRAP : ev_tag + 16'h0001;
      end
    end
  end
endmodule : cpl_event_packer

// >>> design/cpl_pkg.sv
package cpl_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CAPS = 8'h04;
  localparam logic [7:0] REG_HB_TIMEOUT = 8'h08;
  localparam logic [7:0] REG_ACCESS = 8'h0c;
  localparam logic [7:0] REG_MSG_PATH = 8'h10;
  localparam logic [7:0] REG_LINK_PARAM = 8'h14;
  localparam logic [7:0] REG_PTL = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_FAULTS = 8'h20;
  localparam logic [7:0] REG_EVENT_TAG = 8'h24;
  localparam logic [7:0] REG_EVENT_MASK = 8'h28;

  localparam int CTRL_HB_DISABLE = 0;
  localparam int CTRL_STREAM = 1;
  localparam int FLT_CRC = 0;
  localparam int FLT_HEADER = 1;
  localparam int FLT_SHORT = 2;
  localparam int FLT_LONG = 3;
  localparam int FLT_HB = 4;
  localparam int FLT_REVERT = 5;
  localparam int FLT_W = 6;

  localparam int FLAG_RETRY = 15;
  localparam int FLAG_REPLY = 14;

  localparam logic [15:0] HB_TIMEOUT_RST = 16'h0bb8;
  localparam logic [15:0] MSG_PATH_RST = 16'h0001;
  localparam logic [15:0] DEFAULT_PATH = 16'h0000;
  localparam logic [15:0] PTL_RST = 16'h044c;
  localparam logic [7:0] LINK_DEFAULT = 8'h00;
  localparam logic [15:0] TAG_RST = 16'h0000;
  localparam logic [15:0] TAG_WRAP = 16'h0001;
  localparam int MAX_PACKET_BYTES = 1024;
  localparam int CONFIRM_MS = 250;
  localparam int CLK_HZ = 250000000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  localparam logic [1:0] NS_PROTOCOL = 2'h0;
  localparam logic [1:0] NS_TECHNOLOGY = 2'h1;
  localparam logic [1:0] NS_DEVICE = 2'h2;
  localparam logic [11:0] CODE_GENERIC_ERROR = 12'h000;

  typedef enum logic [1:0] {PRIV_AVAILABLE, PRIV_OPEN_EXCL} cpl_priv_e;
  typedef enum logic [2:0] {ACT_NONE, ACT_EXECUTE, ACT_RESEND, ACT_PENDING, ACT_BUSY, ACT_INVALID,
    ACT_DENY, ACT_DISCARD} cpl_action_e;

  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic header_ok;
    logic [15:0] flags;
    logic [15:0] tag;
    logic is_write;
    logic priv_reg;
    logic other_host;
  } cpl_cmd_s;

  typedef struct packed {
    logic valid;
    cpl_action_e action;
    logic reply;
    logic [15:0] tag;
  } cpl_verdict_s;

  typedef struct packed {
    logic [1:0] ns;
    logic [1:0] rsvd;
    logic [11:0] code;
  } cpl_event_code_s;
endpackage : cpl_pkg

// >>> design/cpl_rx_guard.sv
`timescale 1ns/1ps
module cpl_rx_guard (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ms_tick,
  input wire logic [15:0] limit_ms,
  input wire logic rx_byte,
  input wire logic rx_first,
  input wire logic rx_done,
  input wire logic bad_pkt,
  output logic short_fault,
  output logic long_fault,
  output logic flush
);
  logic in_pkt_q;
  logic [15:0] pkt_ms_q;
  logic [15:0] quiet_ms_q;
  logic [10:0] bytes_q;
  logic expire;
  logic too_long;

  assign expire = in_pkt_q && ms_tick && (pkt_ms_q >= limit_ms);
  assign too_long = in_pkt_q && rx_byte && (bytes_q >= 11'(cpl_pkg::MAX_PACKET_BYTES));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_pkt_q <= 1'b0;
      pkt_ms_q <= 16'h0000;
      bytes_q <= 11'h000;
    end else if (flush || expire || too_long || rx_done) begin
      in_pkt_q <= 1'b0;
    end else if (rx_first) begin
      in_pkt_q <= 1'b1;
      pkt_ms_q <= 16'h0000;
      bytes_q <= 11'h001;
    end else if (in_pkt_q) begin
      if (ms_tick) pkt_ms_q <= pkt_ms_q + 16'h0001;
      if (rx_byte) bytes_q <= bytes_q + 11'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      short_fault <= 1'b0;
      long_fault <= 1'b0;
    end else begin
      short_fault <= expire;
      long_fault <= too_long;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush <= 1'b0;
      quiet_ms_q <= 16'h0000;
    end else if (expire || too_long || bad_pkt) begin
      flush <= 1'b1;
      quiet_ms_q <= 16'h0000;
    end else if (flush) begin
      if (rx_byte) quiet_ms_q <= 16'h0000;
      else if (ms_tick && quiet_ms_q >= limit_ms) flush <= 1'b0;
      else if (ms_tick) quiet_ms_q <= quiet_ms_q + 16'h0001;
    end
  end
endmodule : cpl_rx_guard

// >>> design/cpl_supervisor.sv
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module cpl_supervisor #(
  parameter int N_SRC = 4,
  parameter int CYCLES_PER_MS = cpl_pkg::CYCLES_PER_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cpl_pkg::cpl_cmd_s cmd,
  input wire logic cmd_busy,
  input wire logic ack_sent,
  input wire logic rx_byte,
  input wire logic rx_first,
  input wire logic rx_done,
  input wire logic [N_SRC-1:0] ev_in,
  input wire logic ev_tx_ready,
  input wire logic ev_reply_valid,
  input wire logic [15:0] ev_reply_tag,
  output cpl_pkg::cpl_verdict_s verdict,
  output logic ev_send,
  output logic [N_SRC-1:0] ev_sent_mask,
  output logic [15:0] ev_tag,
  output logic [15:0] ev_path,
  output logic [7:0] link_param,
  output logic stream_en,
  output logic flush
);
  logic [1:0] ctrl_q;
  logic [15:0] hb_timeout_q;
  cpl_pkg::cpl_priv_e priv_q;
  logic [15:0] msg_path_q;
  logic [7:0] link_old_q;
  logic confirm_q;
  logic [15:0] ptl_q;
  logic [cpl_pkg::FLT_W-1:0] faults_q;
  logic [N_SRC-1:0] ev_mask_q;
  logic [31:0] ms_cnt_q;
  logic ms_tick;
  logic [15:0] hb_ms_q;
  logic hb_run_q;
  logic [15:0] cf_ms_q;
  logic cf_run_q;
  logic revert_wait_q;
  logic [15:0] last_tag_q;
  logic last_valid_q;
  logic link_write_q;
  logic dp_q;
  logic dp_write_q;
  logic [7:0] dp_addr_q;
  logic addr_phase;
  logic wr;
  logic short_fault;
  logic long_fault;
  logic ev_busy;
  logic hb_expire;
  logic cf_expire;
  logic revert;
  logic bad_pkt;
  logic ev_ev_in_unused;

  assign addr_phase = hsel && htrans[1] && hready;
  assign wr = dp_q && dp_write_q;
  assign bad_pkt = cmd.valid && (!cmd.crc_ok || !cmd.header_ok);
  assign hb_expire = hb_run_q && ms_tick && (hb_ms_q >= hb_timeout_q) && !cmd_busy;
  assign cf_expire = cf_run_q && ms_tick && (cf_ms_q >= 16'(cpl_pkg::CONFIRM_MS));
  assign revert = hb_expire || (revert_wait_q && ack_sent);

  // AHB-Lite slave, zero wait, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        dp_q <= addr_phase;
        dp_write_q <= hwrite;
        dp_addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        cpl_pkg::REG_CTRL: hrdata <= {30'h0, ctrl_q};
        cpl_pkg::REG_CAPS: hrdata <= 32'h0000_0001;
        cpl_pkg::REG_HB_TIMEOUT: hrdata <= {16'h0, hb_timeout_q};
        cpl_pkg::REG_ACCESS: hrdata <= {31'h0, priv_q == cpl_pkg::PRIV_OPEN_EXCL};
        cpl_pkg::REG_MSG_PATH: hrdata <= {16'h0, msg_path_q};
        cpl_pkg::REG_LINK_PARAM: hrdata <= {24'h0, link_param};
        cpl_pkg::REG_PTL: hrdata <= {16'h0, ptl_q};
        cpl_pkg::REG_STATUS: hrdata <= {26'h0, ev_busy, hb_run_q, flush, confirm_q, stream_en,
          priv_q == cpl_pkg::PRIV_OPEN_EXCL};
        cpl_pkg::REG_FAULTS: hrdata <= {26'h0, faults_q};
        cpl_pkg::REG_EVENT_TAG: hrdata <= {16'h0, ev_tag};
        cpl_pkg::REG_EVENT_MASK: hrdata <= {{(32-N_SRC){1'b0}}, ev_mask_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= 2'h0;
      hb_timeout_q <= cpl_pkg::HB_TIMEOUT_RST;
      msg_path_q <= cpl_pkg::MSG_PATH_RST;
      ptl_q <= cpl_pkg::PTL_RST;
      ev_mask_q <= '1;
    end else begin
      if (wr && dp_addr_q == cpl_pkg::REG_CTRL) ctrl_q <= hwdata[1:0];
      if (wr && dp_addr_q == cpl_pkg::REG_HB_TIMEOUT) hb_timeout_q <= hwdata[15:0];
      if (wr && dp_addr_q == cpl_pkg::REG_MSG_PATH && hwdata[15:0] != cpl_pkg::DEFAULT_PATH)
        msg_path_q <= hwdata[15:0];
      if (wr && dp_addr_q == cpl_pkg::REG_PTL) ptl_q <= hwdata[15:0];
      if (wr && dp_addr_q == cpl_pkg::REG_EVENT_MASK) ev_mask_q <= hwdata[N_SRC-1:0];
    end
  end

  // Millisecond prescaler
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_cnt_q <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end else begin
      ms_tick <= (ms_cnt_q == 32'(CYCLES_PER_MS - 1));
      ms_cnt_q <= (ms_cnt_q == 32'(CYCLES_PER_MS - 1)) ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
    end
  end

  // Access privilege and its deferred close
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      priv_q <= cpl_pkg::PRIV_AVAILABLE;
      revert_wait_q <= 1'b0;
    end else if (hb_expire) begin
      priv_q <= cpl_pkg::PRIV_AVAILABLE;
      revert_wait_q <= 1'b0;
    end else if (wr && dp_addr_q == cpl_pkg::REG_ACCESS) begin
      if (hwdata[0]) begin
        priv_q <= cpl_pkg::PRIV_OPEN_EXCL;
        revert_wait_q <= 1'b0;
      end else if (priv_q == cpl_pkg::PRIV_OPEN_EXCL) begin
        priv_q <= cpl_pkg::PRIV_AVAILABLE;
        revert_wait_q <= 1'b1;
      end
    end else if (revert_wait_q && ack_sent) begin
      revert_wait_q <= 1'b0;
    end
  end

  // Heartbeat watchdog, frozen while a command is pending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hb_run_q <= 1'b0;
      hb_ms_q <= 16'h0000;
    end else if (hb_expire || ctrl_q[cpl_pkg::CTRL_HB_DISABLE] || priv_q == cpl_pkg::PRIV_AVAILABLE) begin
      hb_run_q <= wr && dp_addr_q == cpl_pkg::REG_ACCESS && hwdata[0]
        && !ctrl_q[cpl_pkg::CTRL_HB_DISABLE];
      hb_ms_q <= 16'h0000;
    end else if (dp_q || (verdict.valid && verdict.action == cpl_pkg::ACT_EXECUTE)) begin
      hb_run_q <= 1'b1;
      hb_ms_q <= 16'h0000;
    end else if (hb_run_q && ms_tick && !cmd_busy) begin
      hb_ms_q <= hb_ms_q + 16'h0001;
    end
  end

  // Streaming follows the control bit only while open
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) stream_en <= 1'b0;
    else if (revert || priv_q == cpl_pkg::PRIV_AVAILABLE) stream_en <= 1'b0;
    else stream_en <= ctrl_q[cpl_pkg::CTRL_STREAM];
  end

  // Link parameters with confirmed switch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_param <= cpl_pkg::LINK_DEFAULT;
      link_old_q <= cpl_pkg::LINK_DEFAULT;
      confirm_q <= 1'b0;
      link_write_q <= 1'b0;
    end else if (revert) begin
      link_param <= cpl_pkg::LINK_DEFAULT;
      confirm_q <= 1'b0;
      link_write_q <= 1'b0;
    end else if (cf_expire) begin
      link_param <= link_old_q;
      confirm_q <= 1'b0;
    end else if (wr && dp_addr_q == cpl_pkg::REG_LINK_PARAM) begin
      if (confirm_q && hwdata[7:0] == link_param) begin
        confirm_q <= 1'b0;
      end else if (hwdata[7:0] != link_param) begin
        link_old_q <= confirm_q ? link_old_q : link_param;
        link_param <= hwdata[7:0];
        confirm_q <= 1'b1;
        link_write_q <= 1'b1;
      end
    end else if (link_write_q && ack_sent) begin
      link_write_q <= 1'b0;
    end
  end

  // Confirm window opens when the acknowledge of the change is sent
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cf_run_q <= 1'b0;
      cf_ms_q <= 16'h0000;
    end else if (!confirm_q || cf_expire || revert) begin
      cf_run_q <= 1'b0;
      cf_ms_q <= 16'h0000;
    end else if (link_write_q && ack_sent) begin
      cf_run_q <= 1'b1;
      cf_ms_q <= 16'h0000;
    end else if (cf_run_q && ms_tick) begin
      cf_ms_q <= cf_ms_q + 16'h0001;
    end
  end

  // Command verdicts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      verdict <= '0;
      last_tag_q <= cpl_pkg::TAG_RST;
      last_valid_q <= 1'b0;
    end else begin
      verdict.valid <= cmd.valid;
      verdict.tag <= cmd.tag;
      verdict.reply <= 1'b0;
      verdict.action <= cpl_pkg::ACT_NONE;
      if (revert) last_valid_q <= 1'b0;
      if (!cmd.valid) begin
        verdict.action <= cpl_pkg::ACT_NONE;
      end else if (bad_pkt || flush) begin
        verdict.action <= cpl_pkg::ACT_DISCARD;
      end else if (cmd.tag == 16'h0000) begin
        verdict.reply <= 1'b1;
        verdict.action <= cmd.is_write ? cpl_pkg::ACT_INVALID : cpl_pkg::ACT_EXECUTE;
      end else if (last_valid_q && cmd.tag == last_tag_q) begin
        verdict.reply <= 1'b1;
        verdict.action <= cmd_busy ? cpl_pkg::ACT_PENDING : cpl_pkg::ACT_RESEND;
      end else if (cmd_busy) begin
        verdict.reply <= 1'b1;
        verdict.action <= cpl_pkg::ACT_BUSY;
      end else if (priv_q == cpl_pkg::PRIV_OPEN_EXCL && cmd.other_host && !(cmd.priv_reg && !cmd.is_write)) begin
        verdict.reply <= 1'b1;
        verdict.action <= cpl_pkg::ACT_DENY;
      end else begin
        verdict.reply <= cmd.flags[cpl_pkg::FLAG_REPLY] || !cmd.is_write;
        verdict.action <= cpl_pkg::ACT_EXECUTE;
        last_tag_q <= cmd.tag;
        last_valid_q <= 1'b1;
      end
    end
  end

  // Sticky faults, write one to clear, a new event wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      faults_q <= '0;
    end else begin
      faults_q <= (faults_q & ~((wr && dp_addr_q == cpl_pkg::REG_FAULTS) ? hwdata[cpl_pkg::FLT_W-1:0] : '0))
        | {cf_expire, hb_expire, long_fault, short_fault,
           cmd.valid && !cmd.header_ok, cmd.valid && !cmd.crc_ok};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) ev_path <= cpl_pkg::MSG_PATH_RST;
    else ev_path <= msg_path_q;
  end

  cpl_rx_guard u_guard (
    .hclk(hclk),
    .hresetn(hresetn),
    .ms_tick(ms_tick),
    .limit_ms(ptl_q),
    .rx_byte(rx_byte),
    .rx_first(rx_first),
    .rx_done(rx_done),
    .bad_pkt(bad_pkt),
    .short_fault(short_fault),
    .long_fault(long_fault),
    .flush(flush)
  );

  cpl_event_packer #(.N_SRC(N_SRC)) u_events (
    .hclk(hclk),
    .hresetn(hresetn),
    .ev_in(ev_in),
    .ev_enable(ev_mask_q),
    .tx_ready(ev_tx_ready),
    .reply_valid(ev_reply_valid),
    .reply_tag(ev_reply_tag),
    .ev_send(ev_send),
    .ev_sent_mask(ev_sent_mask),
    .ev_tag(ev_tag),
    .in_flight(ev_busy)
  );

  assign ev_ev_in_unused = ^hsize;
endmodule : cpl_supervisor

// >>> tb/cpl_host_evt.sv
`timescale 1ns/1ps
module cpl_host_evt (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic ev_send,
  input wire logic [15:0] ev_tag,
  output logic ev_tx_ready,
  output logic ev_reply_valid,
  output logic [15:0] ev_reply_tag
);
  logic [3:0] cnt_q;
  logic [15:0] tag_q;
  assign ev_tx_ready = (cnt_q == 4'h0);
  // Answer each event command with its own tag, fast or slow
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      tag_q <= 16'h0000;
      ev_reply_valid <= 1'b0;
      ev_reply_tag <= 16'h0000;
    end else begin
      ev_reply_valid <= 1'b0;
      ev_reply_tag <= ~ev_reply_tag;
      if (ev_send) begin
        cnt_q <= slow ? 4'h9 : 4'h1;
        tag_q <= ev_tag;
      end else if (cnt_q == 4'h1) begin
        ev_reply_valid <= 1'b1;
        ev_reply_tag <= tag_q;
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule : cpl_host_evt

// >>> tb/cpl_sup_assertions.sv
`timescale 1ns/1ps
module cpl_sup_assertions #(
  parameter int N_SRC = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire cpl_pkg::cpl_cmd_s cmd,
  input wire cpl_pkg::cpl_verdict_s verdict,
  input wire logic flush,
  input wire logic ev_send,
  input wire logic [N_SRC-1:0] ev_sent_mask,
  input wire logic [15:0] ev_tag,
  input wire logic [15:0] ev_path
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus not okay");
  discard_quiet_a: assert property (cmd.valid && !(cmd.crc_ok && cmd.header_ok) |=>
    verdict.valid && verdict.action == cpl_pkg::ACT_DISCARD && !verdict.reply) else $error("bad packet answered");
  tag_echo_a: assert property (cmd.valid |=> verdict.valid && verdict.tag == $past(cmd.tag))
    else $error("verdict tag wrong");
  zero_read_a: assert property (cmd.valid && cmd.crc_ok && cmd.header_ok && !flush && cmd.tag == 16'h0000
    && !cmd.is_write |=> verdict.action == cpl_pkg::ACT_EXECUTE) else $error("tag zero read not run");
  zero_write_a: assert property (cmd.valid && cmd.crc_ok && cmd.header_ok && !flush && cmd.tag == 16'h0000
    && cmd.is_write |=> verdict.action == cpl_pkg::ACT_INVALID) else $error("tag zero write taken");
  flush_start_a: assert property (cmd.valid && !cmd.crc_ok |-> ##[1:3] flush) else $error("no flush");
  ev_packed_a: assert property (ev_send |-> ev_sent_mask != '0) else $error("empty event command");
  ev_tag_step_a: assert property ($changed(ev_tag) |-> ev_tag == $past(ev_tag) + 16'h0001
    || (ev_tag == cpl_pkg::TAG_WRAP && $past(ev_tag) == 16'hffff)) else $error("event tag jump");
  ev_path_a: assert property (ev_path != cpl_pkg::DEFAULT_PATH) else $error("event path on default");
endmodule : cpl_sup_assertions
bind cpl_supervisor cpl_sup_assertions #(.N_SRC(N_SRC)) cpl_sup_assertions_i (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .cmd(cmd), .verdict(verdict), .flush(flush), .ev_send(ev_send),
  .ev_sent_mask(ev_sent_mask), .ev_tag(ev_tag), .ev_path(ev_path));

// >>> tb/tb_cpl_supervisor.sv
`timescale 1ns/1ps
module tb_cpl_supervisor;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  cpl_pkg::cpl_cmd_s cmd = '0;
  logic cmd_busy = 1'b0;
  logic ack_sent = 1'b0;
  logic rx_first = 1'b0;
  logic [3:0] ev_in = 4'h0;
  logic slow = 1'b1;
  logic ev_tx_ready;
  logic ev_reply_valid;
  logic [15:0] ev_reply_tag;
  cpl_pkg::cpl_verdict_s verdict;
  logic ev_send;
  logic [3:0] ev_sent_mask;
  logic [15:0] ev_tag;
  logic [15:0] ev_path;
  logic [7:0] link_param;
  logic stream_en;
  logic flush;
  logic [31:0] rd;
  int n_errors = 0;
  int n_tests = 0;
  int n_cyc = 0;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  cpl_supervisor #(.N_SRC(4), .CYCLES_PER_MS(10)) cpl_supervisor_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmd(cmd), .cmd_busy(cmd_busy),
    .ack_sent(ack_sent), .rx_byte(1'b0), .rx_first(rx_first), .rx_done(1'b0), .ev_in(ev_in),
    .ev_tx_ready(ev_tx_ready), .ev_reply_valid(ev_reply_valid), .ev_reply_tag(ev_reply_tag),
    .verdict(verdict), .ev_send(ev_send), .ev_sent_mask(ev_sent_mask), .ev_tag(ev_tag), .ev_path(ev_path),
    .link_param(link_param), .stream_en(stream_en), .flush(flush));
  cpl_host_evt cpl_host_evt_i (.hclk(hclk), .hresetn(hresetn), .slow(slow), .ev_send(ev_send),
    .ev_tag(ev_tag), .ev_tx_ready(ev_tx_ready), .ev_reply_valid(ev_reply_valid),
    .ev_reply_tag(ev_reply_tag));
  task automatic print_verdict();
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic ack();
    @(posedge hclk);
    ack_sent <= 1'b1;
    @(posedge hclk);
    ack_sent <= 1'b0;
  endtask : ack
  task automatic cm(input logic [15:0] t, input logic [2:0] wco, input logic crc, input cpl_pkg::cpl_action_e ex);
    @(posedge hclk);
    cmd <= {1'b1, crc, 1'b1, 16'h4000, t, wco};
    @(posedge hclk);
    cmd.valid <= 1'b0;
    @(posedge hclk);
    chk("action", 32'(verdict.action), 32'(ex));
    chk("vtag", 32'(verdict.tag), 32'(t));
  endtask : cm
  task automatic t_reset();
    xfer(0, cpl_pkg::REG_CAPS, 0);
    chk("caps", rd, 32'h1);
    xfer(0, cpl_pkg::REG_HB_TIMEOUT, 0);
    chk("hbto", rd, 32'h0bb8);
    xfer(0, 8'h40, 0);
    chk("unmapped", rd, 32'h0);
    chk("link", 32'(link_param), 32'h0);
    xfer(1, cpl_pkg::REG_MSG_PATH, 0);
    chk("path0", 32'(ev_path), 32'h1);
    xfer(1, cpl_pkg::REG_MSG_PATH, 5);
    repeat (2) @(posedge hclk);
    chk("path5", 32'(ev_path), 32'h5);
  endtask : t_reset
  task automatic ev_wait(input logic [3:0] m, input logic [15:0] t);
    int i;
    for (i = 0; i < 40 && ev_send !== 1'b1; i++) @(posedge hclk);
    chk("evmask", 32'(ev_sent_mask), 32'(m));
    chk("evtag", 32'(ev_tag), 32'(t));
  endtask : ev_wait
  task automatic t_events();
    @(posedge hclk);
    ev_in <= 4'h4;
    @(posedge hclk);
    ev_in <= 4'h0;
    ev_wait(4'h4, 16'h0);
    @(posedge hclk);
    ev_in <= 4'h3;
    @(posedge hclk);
    ev_in <= 4'h0;
    ev_wait(4'h3, 16'h1);
  endtask : t_events
  task automatic t_cmds();
    cm(5, 3'b000, 1, cpl_pkg::ACT_EXECUTE);
    cm(5, 3'b000, 1, cpl_pkg::ACT_RESEND);
    cm(0, 3'b000, 1, cpl_pkg::ACT_EXECUTE);
    cm(0, 3'b000, 1, cpl_pkg::ACT_EXECUTE);
    cm(0, 3'b100, 1, cpl_pkg::ACT_INVALID);
    cmd_busy <= 1'b1;
    cm(6, 3'b000, 1, cpl_pkg::ACT_BUSY);
    cm(5, 3'b000, 1, cpl_pkg::ACT_PENDING);
    cmd_busy <= 1'b0;
    xfer(1, cpl_pkg::REG_ACCESS, 1);
    cm(7, 3'b001, 1, cpl_pkg::ACT_DENY);
    cm(8, 3'b011, 1, cpl_pkg::ACT_EXECUTE);
    xfer(1, cpl_pkg::REG_ACCESS, 0);
    cm(9, 3'b000, 0, cpl_pkg::ACT_DISCARD);
    repeat (80) @(posedge hclk);
  endtask : t_cmds
  task automatic t_heart();
    xfer(1, cpl_pkg::REG_HB_TIMEOUT, 3);
    xfer(1, cpl_pkg::REG_LINK_PARAM, 2);
    ack();
    xfer(1, cpl_pkg::REG_LINK_PARAM, 2);
    xfer(1, cpl_pkg::REG_CTRL, 2);
    xfer(1, cpl_pkg::REG_ACCESS, 1);
    repeat (20) @(posedge hclk);
    xfer(0, cpl_pkg::REG_ACCESS, 0);
    chk("kept", rd, 32'h1);
    repeat (60) @(posedge hclk);
    chk("stream", 32'(stream_en), 32'h0);
    chk("hblink", 32'(link_param), 32'h0);
    xfer(0, cpl_pkg::REG_FAULTS, 0);
    chk("hbflt", rd & 32'h10, 32'h10);
  endtask : t_heart
  task automatic t_close();
    xfer(1, cpl_pkg::REG_ACCESS, 1);
    xfer(1, cpl_pkg::REG_LINK_PARAM, 5);
    ack();
    xfer(1, cpl_pkg::REG_LINK_PARAM, 5);
    xfer(1, cpl_pkg::REG_ACCESS, 0);
    chk("preack", 32'(link_param), 32'h5);
    ack();
    @(posedge hclk);
    chk("postack", 32'(link_param), 32'h0);
    xfer(1, cpl_pkg::REG_LINK_PARAM, 7);
    ack();
    repeat (2600) @(posedge hclk);
    chk("revert", 32'(link_param), 32'h0);
    xfer(0, cpl_pkg::REG_FAULTS, 0);
    chk("revflt", rd & 32'h20, 32'h20);
  endtask : t_close
  task automatic t_short();
    xfer(1, cpl_pkg::REG_PTL, 3);
    repeat (25) @(posedge hclk);
    rx_first <= 1'b1;
    @(posedge hclk);
    rx_first <= 1'b0;
    repeat (60) @(posedge hclk);
    xfer(0, cpl_pkg::REG_FAULTS, 0);
    chk("short", rd & 32'h4, 32'h4);
  endtask : t_short
  always @(posedge hclk) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_events();
    t_cmds();
    t_heart();
    t_close();
    t_short();
    print_verdict();
  end
endmodule : tb_cpl_supervisor
